// >>> hdl/multi_mode_event_timer.sv
// How it works
// - Edge-off: on at rise, timed off after fall.
// - Edge-off: reset never reasserts a held input.
// - Level-off: rise clears count, fall starts count.
// - Level-off ignores reset; output keeps its state.
// - Cumulative-on adds up all input-high time.
// - Cumulative-off pauses while high, times low.
// - Reset clears cumulative total.
// - Watchdog counts when enabled; rises restart it.
// - Watchdog output holds until reset.
// - Watchdog ignores rises while output asserted.
// - One-shot rise starts uninterruptible count.
// - One-shot rise while on restarts timing.
// - Timebase selectable, real time by default.
// - Synchronized timebase counts master encoder steps.
// - Real time counts one microsecond steps.
// - Preset sampled only when timing starts.
// - Preset is zero to max positive 32-bit.
// - Elapsed count readable, counts up to preset.
// - Elapsed zeroed on reset except in level modes, holds at preset.
// - Enable low forces output off, count zero.
// - Reset acts on rising edge only.
// - Active flag high only while counting.
// - Edge-on: rise starts count, output holds.
`timescale 1ns/1ps
`include "timer_cfg.svh"
module multi_mode_event_timer
  import timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode_sel,
  input wire logic timebase_sel,
  input wire logic encoder_step,
  input wire logic [`COUNT_W-1:0] preset_value,
  input wire logic timer_enable_level,
  input wire logic timer_trigger_in,
  input wire logic timer_clear_pulse,
  output logic timer_result_out,
  output logic timer_counting_flag,
  output logic [`COUNT_W-1:0] elapsed_count
);

  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  tick_if tb ();

  assign tb.timebase_sync = (timebase_t'(timebase_sel) == BASE_SYNC);
  assign tb.encoder_step = encoder_step;

  tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick_gen (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .tb(tb)
  );

  timer_mode_t mode;
  assign mode = timer_mode_t'(mode_sel);

  logic en_q_r;
  logic in_q_r;
  logic clr_q_r;
  logic out_r;
  logic out_nxt;
  logic run_r;
  logic run_nxt;
  logic done_r;
  logic done_nxt;
  logic [`COUNT_W-1:0] elapsed_r;
  logic [`COUNT_W-1:0] elapsed_nxt;
  logic [`COUNT_W-1:0] preset_r;
  logic [`COUNT_W-1:0] preset_nxt;
  logic [`COUNT_W-1:0] preset_in;
  logic in_rise;
  logic in_fall;
  logic clr_rise;
  logic en_rise;
  logic start;

  assign in_rise = timer_trigger_in && !in_q_r;
  assign in_fall = !timer_trigger_in && in_q_r;
  assign clr_rise = timer_clear_pulse && !clr_q_r;
  assign en_rise = timer_enable_level && !en_q_r;

  // Bit 31 is dropped so the preset can never read as negative.
  assign preset_in = {1'b0, preset_value[`PRESET_MSB:0]};

  always_comb begin
    out_nxt = out_r;
    run_nxt = run_r;
    done_nxt = done_r;
    elapsed_nxt = elapsed_r;
    preset_nxt = preset_r;
    start = 1'b0;
    if (run_r && tb.tick) begin
      elapsed_nxt = elapsed_r + `COUNT_W'(1);
    end
    if (!timer_enable_level) begin
      out_nxt = 1'b0;
      run_nxt = 1'b0;
      done_nxt = 1'b0;
      elapsed_nxt = `ELAPSED_RST;
    end else begin
      unique case (mode)
        MODE_EDGE_ON: begin
          if (clr_rise) begin
            out_nxt = 1'b0;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (in_rise && !run_r && !done_r) begin
            start = 1'b1;
          end
        end
        MODE_LEVEL_ON: begin
          if (!timer_trigger_in) begin
            out_nxt = 1'b0;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (!run_r && !done_r) begin
            start = 1'b1;
          end
        end
        MODE_EDGE_OFF: begin
          if (clr_rise) begin
            out_nxt = 1'b0;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (in_rise && !run_r && !done_r) begin
            out_nxt = 1'b1;
          end else if (in_fall && out_r && !run_r) begin
            start = 1'b1;
          end
        end
        MODE_LEVEL_OFF: begin
          if (in_rise) begin
            out_nxt = 1'b1;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (in_fall && out_r) begin
            start = 1'b1;
          end
        end
        MODE_CUM_ON: begin
          if (clr_rise) begin
            out_nxt = 1'b0;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (done_r) begin
            run_nxt = 1'b0;
          end else if (timer_trigger_in) begin
            if (elapsed_r == `ELAPSED_RST && !run_r) begin
              start = 1'b1;
            end else begin
              run_nxt = 1'b1;
            end
          end else begin
            run_nxt = 1'b0;
          end
        end
        MODE_CUM_OFF: begin
          if (clr_rise) begin
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (in_rise) begin
            out_nxt = 1'b1;
            run_nxt = 1'b0;
            if (done_r) begin
              done_nxt = 1'b0;
              elapsed_nxt = `ELAPSED_RST;
            end
          end else if (!timer_trigger_in && out_r && !done_r && !run_r) begin
            if (elapsed_r == `ELAPSED_RST) begin
              start = 1'b1;
            end else begin
              run_nxt = 1'b1;
            end
          end
        end
        MODE_WATCHDOG: begin
          if (clr_rise) begin
            out_nxt = 1'b0;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (in_rise && !out_r) begin
            start = 1'b1;
          end else if (en_rise || (!run_r && !done_r)) begin
            start = 1'b1;
          end
        end
        MODE_ONE_SHOT: begin
          if (clr_rise) begin
            out_nxt = 1'b0;
            run_nxt = 1'b0;
            done_nxt = 1'b0;
            elapsed_nxt = `ELAPSED_RST;
          end else if (in_rise && !run_r) begin
            out_nxt = 1'b0;
            start = 1'b1;
          end
        end
      endcase
      if (start) begin
        run_nxt = 1'b1;
        done_nxt = 1'b0;
        elapsed_nxt = `ELAPSED_RST;
        preset_nxt = preset_in;
      end
      // Completion is checked on the next value so a zero preset ends at once.
      if (run_nxt && elapsed_nxt >= preset_nxt) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
        elapsed_nxt = preset_nxt;
        unique case (mode)
          MODE_EDGE_OFF, MODE_LEVEL_OFF, MODE_CUM_OFF: out_nxt = 1'b0;
          default: out_nxt = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      en_q_r <= 1'b0;
      in_q_r <= 1'b0;
      clr_q_r <= 1'b0;
      out_r <= 1'b0;
      run_r <= 1'b0;
      done_r <= 1'b0;
      elapsed_r <= `ELAPSED_RST;
      preset_r <= `PRESET_RST;
    end else begin
      en_q_r <= timer_enable_level;
      in_q_r <= timer_trigger_in;
      clr_q_r <= timer_clear_pulse;
      out_r <= out_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
      elapsed_r <= elapsed_nxt;
      preset_r <= preset_nxt;
    end
  end

  assign timer_result_out = out_r;
  assign timer_counting_flag = run_r;
  assign elapsed_count = elapsed_r;

endmodule // multi_mode_event_timer

// >>> hdl/tick_gen.sv
`timescale 1ns/1ps
`include "timer_cfg.svh"
module tick_gen
  import timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_sync_n,
  tick_if.gen tb
);

  localparam logic [`TICK_CNT_W-1:0] TICK_LAST = `TICK_CNT_W'(TICK_CYCLES - 1);

  logic [`TICK_CNT_W-1:0] div_r;
  logic [`TICK_CNT_W-1:0] div_nxt;
  logic tick_r;
  logic tick_nxt;

  // The microsecond strobe runs free so real time never drifts with mode changes.
  always_comb begin
    div_nxt = (div_r == TICK_LAST) ? '0 : div_r + `TICK_CNT_W'(1);
    if (tb.timebase_sync) begin
      tick_nxt = tb.encoder_step;
    end else begin
      tick_nxt = (div_r == TICK_LAST);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tb.tick = tick_r;

endmodule // tick_gen

// >>> shared/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  logic timebase_sync;
  logic encoder_step;
  logic tick;

  modport gen (
    input timebase_sync,
    input encoder_step,
    output tick
  );

  modport user (
    output timebase_sync,
    output encoder_step,
    input tick
  );
endinterface

// >>> shared/timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Controller clock and the real-time resolution of one count.
`define MCLK_PERIOD_PS 4000
`define TICK_PERIOD_PS 1000000
`define TICK_CYCLES (`TICK_PERIOD_PS / `MCLK_PERIOD_PS)
`define TICK_CNT_W 8

// Preset and elapsed count layout.
`define COUNT_W 32
`define PRESET_MAX 32'h7FFFFFFF
`define PRESET_MSB 30

// Reset values.
`define ELAPSED_RST 32'h00000000
`define PRESET_RST 32'h00000000

`endif

// >>> shared/timer_pkg.sv
package timer_pkg;

  typedef enum logic [2:0] {
    MODE_EDGE_ON = 3'h0,
    MODE_LEVEL_ON = 3'h1,
    MODE_EDGE_OFF = 3'h2,
    MODE_LEVEL_OFF = 3'h3,
    MODE_CUM_ON = 3'h4,
    MODE_CUM_OFF = 3'h5,
    MODE_WATCHDOG = 3'h6,
    MODE_ONE_SHOT = 3'h7
  } timer_mode_t;

  typedef enum logic {
    BASE_REALTIME = 1'h0,
    BASE_SYNC = 1'h1
  } timebase_t;

endpackage

// >>> tb/multi_mode_event_timer_tb.sv
`timescale 1ns/1ps
`include "timer_cfg.svh"
module multi_mode_event_timer_tb;
  import timer_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ts = 1'b1;
  logic st = 1'b0;
  logic en = 1'b0;
  logic tg = 1'b0;
  logic cl = 1'b0;
  logic [2:0] md = 3'h6;
  logic [`COUNT_W-1:0] pv = 32'h00000003;
  logic out;
  logic fl;
  logic [`COUNT_W-1:0] el;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int p;
  multi_mode_event_timer #(.TICK_CYCLES(4)) dut (.mclk(mclk), .rst_n(rst_n), .mode_sel(md),
    .timebase_sel(ts), .encoder_step(st), .preset_value(pv), .timer_enable_level(en),
    .timer_trigger_in(tg), .timer_clear_pulse(cl), .timer_result_out(out),
    .timer_counting_flag(fl), .elapsed_count(el));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task cy(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task drv(input logic t, input logic c, input logic e);
    @(posedge mclk);
    tg <= t;
    cl <= c;
    en <= e;
    cy(3);
  endtask
  // Each pulse is one master distance unit in the synchronized timebase.
  task steps(input int n);
    repeat (n) begin
      @(posedge mclk) st <= 1'b1;
      @(posedge mclk) st <= 1'b0;
    end
    cy(4);
  endtask
  task chk(input logic o, input logic f, input logic [`COUNT_W-1:0] e);
    samples_checked++;
    if (out !== o || fl !== f || el !== e) begin
      n_mismatch++;
      $display("unexpected t=%0t out %b flag %b elapsed %0d", $time, out, fl, el);
    end
  endtask
  initial begin
    p = $urandom(32'h4892);
    cy(10);
    @(posedge mclk) rst_n <= 1'b1;
    cy(5);
    drv(0, 0, 1);
    steps(2);
    chk(0, 1, 2);
    drv(1, 0, 1);
    chk(0, 1, 0);
    drv(0, 0, 1);
    @(posedge mclk) pv <= 32'h00000005;
    steps(3);
    chk(1, 0, 3);
    drv(1, 0, 1);
    chk(1, 0, 3);
    drv(1, 1, 1);
    steps(1);
    chk(0, 1, 1);
    drv(0, 1, 0);
    chk(0, 0, 0);
    $display("watchdog done");
    p = 1 + $urandom % 4;
    @(posedge mclk);
    md <= 3'h7;
    pv <= p;
    drv(1, 0, 0);
    chk(0, 0, 0);
    drv(0, 0, 1);
    drv(1, 0, 1);
    drv(0, 0, 1);
    steps(p - 1);
    chk(0, 1, p - 1);
    steps(1);
    chk(1, 0, p);
    drv(1, 0, 1);
    chk(0, 1, 0);
    drv(0, 0, 0);
    $display("one shot done");
    @(posedge mclk);
    md <= 3'h4;
    pv <= 32'h00000003;
    drv(1, 0, 1);
    steps(2);
    drv(0, 0, 1);
    steps(1);
    chk(0, 0, 2);
    drv(1, 0, 1);
    steps(1);
    chk(1, 0, 3);
    drv(0, 0, 1);
    drv(0, 1, 1);
    chk(0, 0, 0);
    drv(0, 0, 0);
    $display("cumulative on done");
    @(posedge mclk) md <= 3'h2;
    drv(0, 0, 1);
    drv(1, 0, 1);
    chk(1, 0, 0);
    drv(0, 0, 1);
    chk(1, 1, 0);
    drv(1, 0, 1);
    steps(3);
    chk(0, 0, 3);
    drv(1, 1, 1);
    chk(0, 0, 0);
    $display("edge off done");
    drv(0, 0, 0);
    @(posedge mclk);
    md <= 3'h0;
    ts <= 1'b0;
    drv(0, 0, 1);
    @(posedge mclk) tg <= 1'b1;
    cy(1);
    chk(0, 1, 0);
    drv(0, 0, 1);
    cy(16);
    chk(1, 0, 3);
    drv(0, 1, 1);
    chk(0, 0, 0);
    $display("edge on done");
    drv(0, 0, 0);
    @(posedge mclk);
    md <= 3'h1;
    ts <= 1'b1;
    drv(1, 0, 1);
    steps(2);
    chk(0, 1, 2);
    drv(0, 0, 1);
    chk(0, 0, 0);
    drv(1, 0, 1);
    steps(3);
    chk(1, 0, 3);
    drv(0, 0, 1);
    chk(0, 0, 0);
    $display("level on done");
    @(posedge mclk) md <= 3'h3;
    drv(1, 0, 1);
    chk(1, 0, 0);
    drv(0, 0, 1);
    steps(2);
    chk(1, 1, 2);
    drv(1, 0, 1);
    chk(1, 0, 0);
    drv(0, 0, 1);
    steps(3);
    chk(0, 0, 3);
    drv(0, 1, 1);
    chk(0, 0, 3);
    $display("level off done");
    drv(0, 0, 0);
    @(posedge mclk) md <= 3'h5;
    drv(1, 0, 1);
    drv(0, 0, 1);
    steps(2);
    drv(1, 0, 1);
    steps(1);
    chk(1, 0, 2);
    drv(0, 0, 1);
    chk(1, 1, 2);
    steps(1);
    chk(0, 0, 3);
    drv(0, 1, 1);
    chk(0, 0, 0);
    $display("cumulative off done");
    summarize();
  end
endmodule // multi_mode_event_timer_tb

// >>> tb/timer_properties.sv
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_properties
  import timer_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode_sel,
  input wire logic timebase_sel,
  input wire logic encoder_step,
  input wire logic [`COUNT_W-1:0] preset_value,
  input wire logic timer_enable_level,
  input wire logic timer_trigger_in,
  input wire logic timer_clear_pulse,
  input wire logic timer_result_out,
  input wire logic timer_counting_flag,
  input wire logic [`COUNT_W-1:0] elapsed_count
);
  logic clr_r;
  logic trg_r;
  logic cr;
  logic tr;
  logic wd;
  logic en;
  logic [`COUNT_W-1:0] el;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clr_r <= 1'b0;
      trg_r <= 1'b0;
    end else begin
      clr_r <= timer_clear_pulse;
      trg_r <= timer_trigger_in;
    end
  end
  // Rising edges are found against the previous sampled value.
  assign cr = timer_clear_pulse & ~clr_r;
  assign tr = timer_trigger_in & ~trg_r;
  assign en = timer_enable_level;
  assign el = elapsed_count;
  assign wd = en & ~cr & timer_result_out;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_disable_clears: assert property (!en |=> !timer_result_out && !timer_counting_flag && el == 0)
    else $error("output or count alive while disabled");
  a_count_steps: assert property ($changed(el) |-> el == 0 || el == $past(el) + 1)
    else $error("elapsed count jumped");
  a_count_active: assert property (el > $past(el) |-> timer_counting_flag || $past(timer_counting_flag))
    else $error("count advanced while not counting");
  a_wd_hold: assert property (mode_sel == MODE_WATCHDOG && wd |=> timer_result_out)
    else $error("watchdog output dropped without clear");
  a_wd_ignore: assert property (mode_sel == MODE_WATCHDOG && wd && tr |=> $stable(el))
    else $error("watchdog rise changed count while output on");
  a_clear_zero: assert property (cr && en && mode_sel != MODE_LEVEL_ON && mode_sel != MODE_LEVEL_OFF
    |=> el == 0)
    else $error("clear did not zero count");
  a_shot_retrig: assert property (mode_sel == MODE_ONE_SHOT && wd && tr |=> !timer_result_out && el == 0)
    else $error("one shot retrigger did not restart");
  a_edgeoff_held: assert property (mode_sel == MODE_EDGE_OFF && cr && en && !tr |=> !timer_result_out)
    else $error("held input reasserted output");
  a_cum_keep: assert property (mode_sel == MODE_CUM_ON && en && !cr && $fell(timer_trigger_in)
    |=> el >= $past(el))
    else $error("cumulative count lost on fall");
  c_wd_done: cover property (mode_sel == MODE_WATCHDOG && timer_result_out);
  c_shot_retrig: cover property (mode_sel == MODE_ONE_SHOT && wd && tr);
  c_clear: cover property (cr && en);
endmodule // timer_properties
bind multi_mode_event_timer timer_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .mclk(mclk), .rst_n(rst_n), .mode_sel(mode_sel), .timebase_sel(timebase_sel),
  .encoder_step(encoder_step), .preset_value(preset_value),
  .timer_enable_level(timer_enable_level), .timer_trigger_in(timer_trigger_in),
  .timer_clear_pulse(timer_clear_pulse), .timer_result_out(timer_result_out),
  .timer_counting_flag(timer_counting_flag), .elapsed_count(elapsed_count));
